// ==== rtl/timer_io_consts.svh ====
`ifndef TIMER_IO_CONSTS_SVH
`define TIMER_IO_CONSTS_SVH

// Register offsets, byte addresses on the register port
`define OFS_CH0_CTRL_A 8'h00
`define OFS_CH0_CTRL_C 8'h04
`define OFS_CH1_CTRL_A 8'h08
`define OFS_CH0_MODE 8'h0C
`define OFS_CH0_GR_A 8'h10
`define OFS_CH0_GR_C 8'h14
`define OFS_CH1_GR_A 8'h18
`define OFS_PIN_STATUS 8'h1C

// Field layout
`define FUNC_MSB 3
`define FUNC_LSB 0
`define MODE_BFA_BIT 4
`define FUNC_RESET 4'h0
`define GR_RESET_BIT 1'b1

// Low two bits of the function field
`define ACT_OFF 2'b00
`define ACT_LOW 2'b01
`define ACT_HIGH 2'b10
`define ACT_TOGGLE 2'b11

// Slot numbering
`define SLOT_CH0_A 0
`define SLOT_CH0_C 1
`define SLOT_CH1_A 2
`define SLOT_COUNT 3

`endif

// ==== rtl/timer_io_pkg.sv ====
package timer_io_pkg;

   // One register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   // Function select field, bit 3 down to bit 0
   typedef struct packed {
      logic in_mode;
      logic init_high;
      logic [1:0] low;
   } func_sel_type;

endpackage

// ==== rtl/timer_io_control_a_c.sv ====
`include "timer_io_consts.svh"

module timer_io_control_a_c
   import timer_io_pkg::*;
#(
   parameter int GR_WIDTH = 16
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Register port
   input wire reg_req_type reg_req,
   output logic [31:0] reg_rdata,
   // Counters and channel 1 count clock pulse
   input wire logic [GR_WIDTH-1:0] ch0_counter,
   input wire logic [GR_WIDTH-1:0] ch1_counter,
   input wire logic ch1_count_tick,
   // Timer pins
   input wire logic ch0_pin_a_in,
   output logic ch0_pin_a_out,
   output logic ch0_pin_a_oe,
   input wire logic ch0_pin_c_in,
   output logic ch0_pin_c_out,
   output logic ch0_pin_c_oe,
   input wire logic ch1_pin_a_in,
   output logic ch1_pin_a_out,
   output logic ch1_pin_a_oe
);

   localparam int N = `SLOT_COUNT;

   func_sel_type func_sel [N];
   logic [GR_WIDTH-1:0] general_reg [N];
   logic buffer_mode_a_enable;
   logic [N-1:0] pin_level;
   logic [N-1:0] sync_first;
   logic [N-1:0] sync_second;
   logic [N-1:0] sync_prev;
   logic [N-1:0] equal_prev;

   function automatic logic pin_hit(func_sel_type f, logic r, logic fl);
      if (f.low[1]) begin
         return r | fl;
      end
      return f.low[0] ? fl : r;
   endfunction

   function automatic logic next_level(func_sel_type f, logic cur);
      unique case (f.low)
         `ACT_LOW: return 1'b0;
         `ACT_HIGH: return 1'b1;
         `ACT_TOGGLE: return ~cur;
         `ACT_OFF: return cur;
      endcase
   endfunction

   // Address decode
   wire logic [N-1:0] ctrl_hit;
   wire logic [N-1:0] gr_hit;
   wire logic mode_hit;
   wire logic status_hit;
   assign ctrl_hit[0] = reg_req.addr == `OFS_CH0_CTRL_A;
   assign ctrl_hit[1] = reg_req.addr == `OFS_CH0_CTRL_C;
   assign ctrl_hit[2] = reg_req.addr == `OFS_CH1_CTRL_A;
   assign gr_hit[0] = reg_req.addr == `OFS_CH0_GR_A;
   assign gr_hit[1] = reg_req.addr == `OFS_CH0_GR_C;
   assign gr_hit[2] = reg_req.addr == `OFS_CH1_GR_A;
   assign mode_hit = reg_req.addr == `OFS_CH0_MODE;
   assign status_hit = reg_req.addr == `OFS_PIN_STATUS;

   wire func_sel_type wr_func;
   assign wr_func = func_sel_type'(reg_req.wdata[`FUNC_MSB:`FUNC_LSB]);

   // Edge detection on synchronised pins
   wire logic [N-1:0] rise;
   wire logic [N-1:0] fall;
   assign rise = sync_second & ~sync_prev;
   assign fall = ~sync_second & sync_prev;

   // Per-slot counters; C shares channel 0 counter
   wire logic [GR_WIDTH-1:0] slot_counter [N];
   assign slot_counter[0] = ch0_counter;
   assign slot_counter[1] = ch0_counter;
   assign slot_counter[2] = ch1_counter;

   // C is a plain buffer while buffer mode is on
   wire logic [N-1:0] blocked;
   assign blocked = {1'b0, buffer_mode_a_enable, 1'b0};

   wire logic [N-1:0] is_compare;
   wire logic [N-1:0] equal_now;
   wire logic [N-1:0] match;
   wire logic [N-1:0] internal_src;
   wire logic [N-1:0] capture;
   wire logic ch0_a_event;

   // Match fires on the first cycle of equality only
   for (genvar i = 0; i < N; i++) begin : g_slot
      assign is_compare[i] = !func_sel[i].in_mode && func_sel[i].low != `ACT_OFF
         && !blocked[i];
      assign equal_now[i] = slot_counter[i] == general_reg[i];
      assign match[i] = is_compare[i] && equal_now[i] && !equal_prev[i];
      assign capture[i] = func_sel[i].in_mode && !blocked[i] && (func_sel[i].init_high ?
         internal_src[i] : pin_hit(func_sel[i], rise[i], fall[i]));
   end

   assign ch0_a_event = match[0] || capture[0];
   assign internal_src[0] = ch1_count_tick;
   assign internal_src[1] = ch1_count_tick;
   assign internal_src[2] = ch0_a_event;

   // Pin drive
   assign ch0_pin_a_out = pin_level[0];
   assign ch0_pin_c_out = pin_level[1];
   assign ch1_pin_a_out = pin_level[2];
   assign ch0_pin_a_oe = is_compare[0];
   assign ch0_pin_c_oe = is_compare[1];
   assign ch1_pin_a_oe = is_compare[2];

   // Read selection
   wire logic [31:0] next_rdata;
   assign next_rdata =
      ctrl_hit[0] ? 32'(func_sel[0]) :
      ctrl_hit[1] ? 32'(func_sel[1]) :
      ctrl_hit[2] ? 32'(func_sel[2]) :
      gr_hit[0] ? 32'(general_reg[0]) :
      gr_hit[1] ? 32'(general_reg[1]) :
      gr_hit[2] ? 32'(general_reg[2]) :
      mode_hit ? 32'(buffer_mode_a_enable) << `MODE_BFA_BIT :
      status_hit ? {26'h000_0000, sync_second, pin_level} : 32'h0000_0000;

   // Two-flop synchronisers on the pins
   // Reset to low; a pin idling high shows one rise after reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync_first <= '0;
         sync_second <= '0;
         sync_prev <= '0;
      end else if (clk_en) begin
         sync_first <= {ch1_pin_a_in, ch0_pin_c_in, ch0_pin_a_in};
         sync_second <= sync_first;
         sync_prev <= sync_second;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata <= '0;
         buffer_mode_a_enable <= 1'b0;
      end else if (clk_en) begin
         reg_rdata <= reg_req.rd ? next_rdata : '0;
         if (reg_req.wr && mode_hit) begin
            buffer_mode_a_enable <= reg_req.wdata[`MODE_BFA_BIT];
         end
      end
   end

   // Function fields and pin levels; a field write loads the initial level
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < N; i++) begin
            func_sel[i] <= func_sel_type'(`FUNC_RESET);
         end
         pin_level <= '0;
         equal_prev <= '0;
      end else if (clk_en) begin
         equal_prev <= equal_now;
         for (int i = 0; i < N; i++) begin
            if (reg_req.wr && ctrl_hit[i]) begin
               func_sel[i] <= wr_func;
               pin_level[i] <= wr_func.init_high;
            end else if (match[i]) begin
               pin_level[i] <= next_level(func_sel[i], pin_level[i]);
            end
         end
      end
   end

   // General registers; hardware events win over software writes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < N; i++) begin
            general_reg[i] <= {GR_WIDTH{`GR_RESET_BIT}};
         end
      end else if (clk_en) begin
         for (int i = 0; i < N; i++) begin
            if (capture[i]) begin
               general_reg[i] <= slot_counter[i];
            end else if (reg_req.wr && gr_hit[i]) begin
               general_reg[i] <= reg_req.wdata[GR_WIDTH-1:0];
            end
         end
         // Buffer transfers between A and C of channel 0
         if (buffer_mode_a_enable && capture[0]) begin
            general_reg[1] <= general_reg[0];
         end else if (buffer_mode_a_enable && match[0]) begin
            general_reg[0] <= general_reg[1];
         end
      end
   end

   low_on_match_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && match[0] && func_sel[0].low == `ACT_LOW && !(reg_req.wr && ctrl_hit[0])
      |=> !ch0_pin_a_out) else $error("pin not low after match");
   high_on_match_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && match[2] && func_sel[2].low == `ACT_HIGH && !(reg_req.wr && ctrl_hit[2])
      |=> ch1_pin_a_out) else $error("pin not high after match");
   toggle_match_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && match[1] && func_sel[1].low == `ACT_TOGGLE && !(reg_req.wr && ctrl_hit[1])
      |=> ch0_pin_c_out != $past(ch0_pin_c_out)) else $error("pin did not toggle");
   init_level_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && reg_req.wr && ctrl_hit[0]
      |=> ch0_pin_a_out == $past(reg_req.wdata[2]) && ch0_pin_a_oe ==
      ($past(reg_req.wdata[1:0]) != `ACT_OFF && !$past(reg_req.wdata[3])))
      else $error("initial level or enable wrong");
   fall_capture_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[0] == func_sel_type'(4'h9) && fall[0] |-> capture[0])
      else $error("falling edge not captured");
   rise_only_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[2] == func_sel_type'(4'h8) && capture[2] |-> rise[2] && !fall[2])
      else $error("capture without rising edge");
   both_edges_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[0].in_mode && !func_sel[0].init_high && func_sel[0].low[1]
      && (rise[0] || fall[0]) |-> capture[0]) else $error("edge not captured");
   count_capture_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[0].in_mode && func_sel[0].init_high && ch1_count_tick |-> capture[0])
      else $error("count tick not captured");
   chain_capture_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[2].in_mode && func_sel[2].init_high && (match[0] || capture[0]) |-> capture[2])
      else $error("channel 0 event not captured");
   buffer_inert_a: assert property (@(posedge core_clk) disable iff (reset)
      buffer_mode_a_enable |-> !ch0_pin_c_oe && !capture[1] && !match[1])
      else $error("buffer register active");
   counter_copy_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && capture[2] |=> general_reg[2] == $past(ch1_counter))
      else $error("capture value wrong");

   // Reset leaves every slot idle with pins released
   reset_state_a: assert property (@(posedge core_clk) disable iff (reset)
      $past(reset) |-> func_sel[0] == func_sel_type'(`FUNC_RESET) && !ch0_pin_a_oe
      && !ch0_pin_a_out && &general_reg[0] && !buffer_mode_a_enable)
      else $error("state not at reset values");
   reset_others_a: assert property (@(posedge core_clk) disable iff (reset)
      $past(reset) |-> !ch0_pin_c_oe && !ch1_pin_a_oe && !ch0_pin_c_out && !ch1_pin_a_out
      && &general_reg[1] && &general_reg[2]) else $error("slot not at reset values");

   // Field writes land whole, one cycle later
   field_load_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && reg_req.wr && ctrl_hit[2]
      |=> 4'(func_sel[2]) == $past(reg_req.wdata[`FUNC_MSB:`FUNC_LSB]))
      else $error("A field not loaded");
   field_load_c_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && reg_req.wr && ctrl_hit[1]
      |=> 4'(func_sel[1]) == $past(reg_req.wdata[`FUNC_MSB:`FUNC_LSB]))
      else $error("C field not loaded");
   field_read_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && reg_req.rd && ctrl_hit[0] |=> reg_rdata == 32'($past(func_sel[0])))
      else $error("field read back wrong");
   mode_load_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && reg_req.wr && mode_hit |=> buffer_mode_a_enable == $past(reg_req.wdata[`MODE_BFA_BIT]))
      else $error("buffer mode not loaded");

   // Pins only move on a match or a field write
   hold_level_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !match[0] && !(reg_req.wr && ctrl_hit[0]) |=> $stable(ch0_pin_a_out))
      else $error("A pin moved without match");
   hold_c_level_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !match[1] && !(reg_req.wr && ctrl_hit[1]) |=> $stable(ch0_pin_c_out))
      else $error("C pin moved without match");
   hold_ch1_level_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !match[2] && !(reg_req.wr && ctrl_hit[2]) |=> $stable(ch1_pin_a_out))
      else $error("channel 1 pin moved without match");

   // Capture sources not covered above
   c_tick_capture_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[1].in_mode && func_sel[1].init_high && !buffer_mode_a_enable && ch1_count_tick
      |-> capture[1]) else $error("C missed count tick");
   c_rise_capture_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[1] == func_sel_type'(4'h8) && !buffer_mode_a_enable && rise[1] |-> capture[1])
      else $error("C missed rising edge");
   pin_source_a: assert property (@(posedge core_clk) disable iff (reset)
      func_sel[2].in_mode && !func_sel[2].init_high && capture[2] |-> rise[2] || fall[2])
      else $error("channel 1 capture without pin edge");
   copy_a_value_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && capture[0] |=> general_reg[0] == $past(ch0_counter))
      else $error("A capture value wrong");
   copy_c_value_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && capture[1] |=> general_reg[1] == $past(ch0_counter))
      else $error("C capture value wrong");

   // Buffer mode trades C's own function for a shadow of A
   to_c_buffer_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && buffer_mode_a_enable && capture[0] |=> general_reg[1] == $past(general_reg[0]))
      else $error("A not moved to buffer");
   to_a_buffer_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && buffer_mode_a_enable && match[0] |=> general_reg[0] == $past(general_reg[1]))
      else $error("buffer not moved to A");

endmodule // timer_io_control_a_c

// ==== sim/far_side_model.sv ====
module far_side_model #(
   parameter int WIDTH = 8
) (
   // Clock and control
   input wire logic core_clk,
   input wire logic reset,
   input wire logic run,
   // Counters
   output logic [WIDTH-1:0] ch0_counter,
   output logic [WIDTH-1:0] ch1_counter,
   output logic ch1_count_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] prescale;
   // Slow channel 1 so its tick is a real pulse, not a constant level
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ch0_counter <= '0;
         ch1_counter <= '0;
         prescale <= 2'h0;
         ch1_count_tick <= 1'b0;
      end else if (run) begin
         ch0_counter <= ch0_counter + 1'b1;
         prescale <= prescale + 1'b1;
         ch1_counter <= ch1_counter + WIDTH'(prescale == 2'h3);
         ch1_count_tick <= (prescale == 2'h3);
      end else begin
         ch1_count_tick <= 1'b0;
      end
   end
endmodule // far_side_model

// ==== sim/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import timer_io_pkg::*;
   localparam int W = 8;
   logic core_clk, reset, run, clk_en;
   reg_req_type reg_req;
   logic [31:0] reg_rdata, data;
   logic [W-1:0] ch0_counter, ch1_counter;
   logic ch1_count_tick;
   logic [2:0] pin_in, outs, oes;
   int bad_count, checked;

   timer_io_control_a_c #(.GR_WIDTH(W)) DUT (.core_clk(core_clk), .reset(reset),
      .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .ch0_counter(ch0_counter),
      .ch1_counter(ch1_counter), .ch1_count_tick(ch1_count_tick),
      .ch0_pin_a_in(pin_in[0]), .ch0_pin_a_out(outs[0]), .ch0_pin_a_oe(oes[0]),
      .ch0_pin_c_in(pin_in[1]), .ch0_pin_c_out(outs[1]), .ch0_pin_c_oe(oes[1]),
      .ch1_pin_a_in(pin_in[2]), .ch1_pin_a_out(outs[2]), .ch1_pin_a_oe(oes[2]));

   far_side_model #(.WIDTH(W)) partner (.core_clk(core_clk), .reset(reset), .run(run),
      .ch0_counter(ch0_counter), .ch1_counter(ch1_counter), .ch1_count_tick(ch1_count_tick));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1;
      data = reg_rdata;
   endtask

   // Bounded wait for a pin level; a full ch1 compare period is 1024 cycles
   task automatic wait_out(input int s, input logic v);
      for (int i = 0; i < 1100 && outs[s] !== v; i++) begin
         @(posedge core_clk);
         #1;
      end
      chk(32'(outs[s]), 32'(v));
   endtask

   // Two sync flops plus edge register plus capture edge fit in six cycles
   task automatic pin(input int s, input logic v);
      @(posedge core_clk);
      pin_in[s] <= v;
      repeat (6) @(posedge core_clk);
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      final_report();
   end

   initial begin
      reg_req = '0;
      run = 1'b0;
      clk_en = 1'b1;
      pin_in = 3'h0;
      reset = 1'b1;
      bad_count = 0;
      checked = 0;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rd(8'h00);
      chk(data, 32'h0000_0000);
      chk(32'(oes), 32'h0000_0000);
      rd(8'h20);
      chk(data, 32'h0000_0000);
      rd(8'h10);
      chk(data, 32'({W{1'b1}}));
      $display("test reset done");
      run <= 1'b1;
      wr(8'h00, 32'h0000_0005);
      chk(32'({outs[0], oes[0]}), 32'h0000_0003);
      wait_out(0, 1'b0);
      wr(8'h04, 32'h0000_0003);
      wait_out(1, 1'b1);
      wait_out(1, 1'b0);
      wr(8'h08, 32'h0000_0002);
      chk(32'(oes[2]), 32'h0000_0001);
      wait_out(2, 1'b1);
      wr(8'h00, 32'h0000_0004);
      chk(32'(oes[0]), 32'h0000_0000);
      wr(8'h04, 32'h0000_0002);
      chk(32'(oes[1]), 32'h0000_0001);
      wr(8'h0C, 32'h0000_0010);
      chk(32'(oes[1]), 32'h0000_0000);
      rd(8'h0C);
      chk(data, 32'h0000_0010);
      wr(8'h0C, 32'h0000_0000);
      $display("test compare done");
      run <= 1'b0;
      wr(8'h00, 32'h0000_0009);
      wr(8'h10, 32'(W'(~ch0_counter)));
      pin(0, 1'b1);
      rd(8'h10);
      chk(data, 32'(W'(~ch0_counter)));
      pin(0, 1'b0);
      rd(8'h10);
      chk(data, 32'(ch0_counter));
      wr(8'h00, 32'h0000_0008);
      wr(8'h10, 32'(W'(~ch0_counter)));
      wr(8'h08, 32'h0000_000C);
      wr(8'h18, 32'(W'(~ch1_counter)));
      pin(0, 1'b1);
      rd(8'h10);
      chk(data, 32'(ch0_counter));
      rd(8'h18);
      chk(data, 32'(ch1_counter));
      for (int c = 10; c <= 11; c++) begin
         wr(8'h08, 32'(c));
         wr(8'h18, 32'(W'(~ch1_counter)));
         pin(2, ~pin_in[2]);
         rd(8'h18);
         chk(data, 32'(ch1_counter));
      end
      rd(8'h1C);
      chk(32'(data[5:3]), 32'h0000_0001);
      $display("test capture done");
      wr(8'h18, 32'h0000_005A);
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(8'h18, 32'h0000_00A5);
      @(posedge core_clk);
      clk_en <= 1'b1;
      rd(8'h18);
      chk(data, 32'h0000_005A);
      $display("test enable done");
      wr(8'h04, 32'h0000_000C);
      wr(8'h14, 32'h0000_0000);
      repeat (8) @(posedge core_clk);
      rd(8'h14);
      chk(data, 32'h0000_0000);
      rd(8'h04);
      chk(data, 32'h0000_000C);
      run <= 1'b1;
      repeat (20) @(posedge core_clk);
      run <= 1'b0;
      rd(8'h14);
      chk(data, 32'(W'(ch0_counter - partner.prescale)));
      $display("test count capture done");
      final_report();
   end
endmodule // testbench
